/* core/ctei_clock_ctrl.sv */
// Clock control task, event and status registers behind an AXI4-Lite slave.
// How it works
// - Start task enables high-frequency crystal oscillator
// - Stop task disables high-frequency crystal oscillator
// - Calibrate task requests RC oscillator calibration
// - Timer start task starts calibration countdown
// - Timer stop task stops calibration countdown
// - Crystal running sets crystal-started event
// - Calibration completion sets calibration-done event
// - Timer started sets timer-started event
// - Timer stopped sets timer-stopped event
// - Enable-set bits enable, read current state
// - Enable-clear bits disable, read current state
// - Low-frequency status gives source and running
// - Status shows crystal start task triggered
// - Status shows low-frequency start triggered
// - Start task snapshots source selection
// - Timer counts interval down, times out, stops
// - Timer ignores tasks until acknowledged
// - Crystal selection runs RC first, switches
`timescale 1ns/1ps
`default_nettype none
module ctei_clock_ctrl #(
  parameter int CT_W = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ctei_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ctei_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator control and readiness
  output logic high_freq_crystal_osc_en,
  input wire logic high_freq_crystal_osc_ready,
  output logic low_freq_clock_en,
  output logic low_freq_crystal_osc_en,
  input wire logic low_freq_rc_osc_ready,
  input wire logic low_freq_crystal_osc_ready,
  // Calibration
  output logic rc_cal_request,
  input wire logic rc_cal_done,
  input wire logic cal_timer_tick,
  // Interrupt
  output logic irq
);

  logic wr_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire;
  logic [31:0] wd;
  logic [ctei_pkg::ADDR_W-1:0] waddr;
  logic t_hf_start, t_hf_stop, t_lf_start, t_lf_stop, t_cal, t_ct_start, t_ct_stop;
  logic [ctei_pkg::NUM_EVT-1:0] evt_q, evt_set, inten_q;
  logic hf_en_q, hf_run_req_q, hf_ok_q;
  logic lf_en_q, lf_run_req_q, lf_xtal_en_q, lf_state_q, lf_done_q;
  logic [1:0] lf_src_q;
  logic [31:0] src_sel_q, src_snap_q;
  logic [CT_W-1:0] ct_ivl_q, ct_cnt_q;
  logic cal_req_q, irq_q;
  ctei_pkg::ctei_ct_e ct_state_q;
  logic ct_timeout;

  // Register hit on the word address; byte offsets are all word aligned.
  function automatic logic hit(input logic [ctei_pkg::ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a[ctei_pkg::ADDR_W-1:2] == off[11:2]);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic mapped(input logic [ctei_pkg::ADDR_W-1:0] a);
    mapped = hit(a, ctei_pkg::OFF_HF_START_TASK) || hit(a, ctei_pkg::OFF_HF_STOP_TASK) ||
      hit(a, ctei_pkg::OFF_LF_START_TASK) || hit(a, ctei_pkg::OFF_LF_STOP_TASK) ||
      hit(a, ctei_pkg::OFF_CAL_TASK) || hit(a, ctei_pkg::OFF_CT_START_TASK) ||
      hit(a, ctei_pkg::OFF_CT_STOP_TASK) || hit(a, ctei_pkg::OFF_EVT_HF_STARTED) ||
      hit(a, ctei_pkg::OFF_EVT_LF_STARTED) || hit(a, ctei_pkg::OFF_EVT_CAL_DONE) ||
      hit(a, ctei_pkg::OFF_EVT_CT_TIMEOUT) || hit(a, ctei_pkg::OFF_EVT_CT_STARTED) ||
      hit(a, ctei_pkg::OFF_EVT_CT_STOPPED) || hit(a, ctei_pkg::OFF_IRQ_EN_SET) ||
      hit(a, ctei_pkg::OFF_IRQ_EN_CLR) || hit(a, ctei_pkg::OFF_HF_RUN_REQ) ||
      hit(a, ctei_pkg::OFF_HF_STATUS) || hit(a, ctei_pkg::OFF_LF_RUN_REQ) ||
      hit(a, ctei_pkg::OFF_LF_STATUS) || hit(a, ctei_pkg::OFF_LF_SRC_SNAP) ||
      hit(a, ctei_pkg::OFF_LF_SRC_SEL) || hit(a, ctei_pkg::OFF_CT_INTERVAL);
  endfunction

  // Address and data are taken together, one write at a time, so no skid storage is needed.
  assign wr_fire = wr_rdy_q & s_axi_awvalid & s_axi_wvalid;
  assign rd_fire = ar_rdy_q & s_axi_arvalid;
  assign waddr = s_axi_awaddr;
  assign wd = s_axi_wdata & lane_mask(s_axi_wstrb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_rdy_q <= 1'b0;
    end else if (wr_rdy_q) begin
      wr_rdy_q <= 1'b0;
    end else begin
      wr_rdy_q <= s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= ctei_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(waddr) ? ctei_pkg::RESP_OKAY : ctei_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_q <= 1'b0;
    end else if (ar_rdy_q) begin
      ar_rdy_q <= 1'b0;
    end else begin
      ar_rdy_q <= s_axi_arvalid & ~rvalid_q;
    end
  end

  // Task triggers: a one written into bit 0; the task words hold no state.
  assign t_hf_start = wr_fire & hit(waddr, ctei_pkg::OFF_HF_START_TASK) & wd[0];
  assign t_hf_stop = wr_fire & hit(waddr, ctei_pkg::OFF_HF_STOP_TASK) & wd[0];
  assign t_lf_start = wr_fire & hit(waddr, ctei_pkg::OFF_LF_START_TASK) & wd[0];
  assign t_lf_stop = wr_fire & hit(waddr, ctei_pkg::OFF_LF_STOP_TASK) & wd[0];
  assign t_cal = wr_fire & hit(waddr, ctei_pkg::OFF_CAL_TASK) & wd[0];
  assign t_ct_start = wr_fire & hit(waddr, ctei_pkg::OFF_CT_START_TASK) & wd[0];
  assign t_ct_stop = wr_fire & hit(waddr, ctei_pkg::OFF_CT_STOP_TASK) & wd[0];

  // High-frequency crystal oscillator; a start in the same write cycle as a stop wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_en_q <= 1'b0;
      hf_run_req_q <= 1'b0;
      hf_ok_q <= 1'b0;
    end else begin
      if (t_hf_start) begin
        hf_en_q <= 1'b1;
        hf_run_req_q <= 1'b1;
      end else if (t_hf_stop) begin
        hf_en_q <= 1'b0;
        hf_run_req_q <= 1'b0;
      end
      hf_ok_q <= hf_en_q & high_freq_crystal_osc_ready;
    end
  end

  // Low-frequency clock control, source snapshot and status.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_en_q <= 1'b0;
      lf_run_req_q <= 1'b0;
      src_snap_q <= ctei_pkg::RST_WORD;
    end else if (t_lf_start) begin
      lf_en_q <= 1'b1;
      lf_run_req_q <= 1'b1;
      src_snap_q <= src_sel_q;
    end else if (t_lf_stop) begin
      lf_en_q <= 1'b0;
      lf_run_req_q <= 1'b0;
    end
  end

  // A crystal selection runs from the RC oscillator until the crystal is up.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_state_q <= 1'b0;
      lf_src_q <= ctei_pkg::SRC_RC;
      lf_xtal_en_q <= 1'b0;
      lf_done_q <= 1'b0;
    end else begin
      lf_state_q <= lf_en_q & low_freq_rc_osc_ready;
      lf_xtal_en_q <= lf_en_q & (src_snap_q[1:0] == ctei_pkg::SRC_XTAL);
      if (src_snap_q[1:0] == ctei_pkg::SRC_XTAL) begin
        lf_src_q <= (lf_en_q & low_freq_crystal_osc_ready) ?
          ctei_pkg::SRC_XTAL : ctei_pkg::SRC_RC;
        lf_done_q <= lf_en_q & low_freq_rc_osc_ready & low_freq_crystal_osc_ready;
      end else begin
        lf_src_q <= src_snap_q[1:0];
        lf_done_q <= lf_en_q & low_freq_rc_osc_ready;
      end
    end
  end

  // Source selection is frozen while the low-frequency clock is enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sel_q <= ctei_pkg::RST_WORD;
      ct_ivl_q <= '0;
    end else if (wr_fire) begin
      if (hit(waddr, ctei_pkg::OFF_LF_SRC_SEL) && !lf_en_q) begin
        src_sel_q <= {14'h0000, wd[ctei_pkg::SEL_EXTERNAL_BIT], wd[ctei_pkg::SEL_BYPASS_BIT],
          14'h0000, wd[1:0]};
      end
      if (hit(waddr, ctei_pkg::OFF_CT_INTERVAL)) begin
        ct_ivl_q <= wd[CT_W-1:0];
      end
    end
  end

  // Calibration request stays up until the oscillator reports completion.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_req_q <= 1'b0;
    end else if (cal_req_q && rc_cal_done) begin
      cal_req_q <= 1'b0;
    end else if (t_cal) begin
      cal_req_q <= 1'b1;
    end
  end

  // Calibration timer; tasks arriving while a start or stop is in flight are dropped.
  assign ct_timeout = (ct_state_q == ctei_pkg::CT_RUN) && cal_timer_tick && (ct_cnt_q <= 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_state_q <= ctei_pkg::CT_IDLE;
      ct_cnt_q <= '0;
    end else begin
      case (ct_state_q)
        ctei_pkg::CT_IDLE: begin
          if (t_ct_start) begin
            ct_state_q <= ctei_pkg::CT_STARTING;
            ct_cnt_q <= ct_ivl_q;
          end
        end
        ctei_pkg::CT_STARTING: begin
          ct_state_q <= ctei_pkg::CT_RUN;
        end
        ctei_pkg::CT_RUN: begin
          if (ct_timeout) begin
            ct_state_q <= ctei_pkg::CT_IDLE;
          end else if (t_ct_stop) begin
            ct_state_q <= ctei_pkg::CT_STOPPING;
          end else if (cal_timer_tick) begin
            ct_cnt_q <= ct_cnt_q - 1'b1;
          end
        end
        ctei_pkg::CT_STOPPING: begin
          ct_state_q <= ctei_pkg::CT_IDLE;
        end
        default: begin
          ct_state_q <= ctei_pkg::CT_IDLE;
        end
      endcase
    end
  end

  // Hardware event sources.
  always_comb begin
    evt_set = '0;
    evt_set[ctei_pkg::EVT_HF] = hf_en_q & high_freq_crystal_osc_ready & ~hf_ok_q;
    evt_set[ctei_pkg::EVT_LF] = lf_en_q & low_freq_rc_osc_ready & ~lf_done_q &
      ((src_snap_q[1:0] != ctei_pkg::SRC_XTAL) | low_freq_crystal_osc_ready);
    evt_set[ctei_pkg::EVT_DONE] = cal_req_q & rc_cal_done;
    evt_set[ctei_pkg::EVT_CAL_TIMER_TIMEOUT] = ct_timeout;
    evt_set[ctei_pkg::EVT_CAL_TIMER_STARTED] = (ct_state_q == ctei_pkg::CT_STARTING) |
      ((ct_state_q == ctei_pkg::CT_RUN) & t_ct_start & ~ct_timeout);
    evt_set[ctei_pkg::EVT_CAL_TIMER_STOPPED] = (ct_state_q == ctei_pkg::CT_STOPPING) |
      ((ct_state_q == ctei_pkg::CT_IDLE) & t_ct_stop);
  end

  // Event flags: a hardware set in the cycle of a software write beats the write.
  for (genvar i = 0; i < ctei_pkg::NUM_EVT; i++) begin : g_evt
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        evt_q[i] <= 1'b0;
      end else if (evt_set[i]) begin
        evt_q[i] <= 1'b1;
      end else if (wr_fire && hit(waddr, ctei_pkg::EVT_OFF[i])) begin
        evt_q[i] <= wd[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inten_q <= '0;
    end else if (wr_fire && hit(waddr, ctei_pkg::OFF_IRQ_EN_SET)) begin
      inten_q <= inten_q | wd[ctei_pkg::NUM_EVT-1:0];
    end else if (wr_fire && hit(waddr, ctei_pkg::OFF_IRQ_EN_CLR)) begin
      inten_q <= inten_q & ~wd[ctei_pkg::NUM_EVT-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_q & inten_q);
    end
  end

  // Read data; task words and unmapped words read zero.
  function automatic logic [31:0] rd_word(input logic [ctei_pkg::ADDR_W-1:0] a);
    logic [31:0] r;
    r = ctei_pkg::RST_WORD;
    for (int k = 0; k < ctei_pkg::NUM_EVT; k++) begin
      if (hit(a, ctei_pkg::EVT_OFF[k])) begin
        r[0] = evt_q[k];
      end
    end
    if (hit(a, ctei_pkg::OFF_IRQ_EN_SET) || hit(a, ctei_pkg::OFF_IRQ_EN_CLR)) begin
      r[ctei_pkg::NUM_EVT-1:0] = inten_q;
    end
    if (hit(a, ctei_pkg::OFF_HF_RUN_REQ)) begin
      r[0] = hf_run_req_q;
    end
    if (hit(a, ctei_pkg::OFF_HF_STATUS)) begin
      r[0] = hf_ok_q;
      r[ctei_pkg::STAT_STATE_BIT] = 1'b1;
    end
    if (hit(a, ctei_pkg::OFF_LF_RUN_REQ)) begin
      r[0] = lf_run_req_q;
    end
    if (hit(a, ctei_pkg::OFF_LF_STATUS)) begin
      r[1:0] = lf_src_q;
      r[ctei_pkg::STAT_STATE_BIT] = lf_state_q;
    end
    if (hit(a, ctei_pkg::OFF_LF_SRC_SNAP)) begin
      r = src_snap_q;
    end
    if (hit(a, ctei_pkg::OFF_LF_SRC_SEL)) begin
      r = src_sel_q;
    end
    if (hit(a, ctei_pkg::OFF_CT_INTERVAL)) begin
      r[CT_W-1:0] = ct_ivl_q;
    end
    rd_word = r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= ctei_pkg::RST_WORD;
      rresp_q <= ctei_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word(s_axi_araddr);
      rresp_q <= mapped(s_axi_araddr) ? ctei_pkg::RESP_OKAY : ctei_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = wr_rdy_q;
  assign s_axi_wready = wr_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign high_freq_crystal_osc_en = hf_en_q;
  assign low_freq_clock_en = lf_en_q;
  assign low_freq_crystal_osc_en = lf_xtal_en_q;
  assign rc_cal_request = cal_req_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hf_start_enable: assert property (t_hf_start |=> hf_en_q ##1 hf_run_req_q)
    else $error("crystal start task did not enable oscillator");
  a_hf_stop_disable: assert property (t_hf_stop && !t_hf_start |=> !hf_en_q [*2])
    else $error("crystal stop task did not disable oscillator");
  a_cal_request: assert property (t_cal && !cal_req_q |=> cal_req_q)
    else $error("calibration task did not raise request");
  a_ct_start_ack: assert property (t_ct_start && ct_state_q == ctei_pkg::CT_IDLE |=>
    ct_state_q == ctei_pkg::CT_STARTING ##1
    (ct_state_q == ctei_pkg::CT_RUN && evt_q[ctei_pkg::EVT_CAL_TIMER_STARTED]))
    else $error("timer start not acknowledged in two cycles");
  a_ct_stop_ack: assert property (t_ct_stop && ct_state_q == ctei_pkg::CT_RUN && !ct_timeout
    |=> ct_state_q == ctei_pkg::CT_STOPPING ##1
    (ct_state_q == ctei_pkg::CT_IDLE && evt_q[ctei_pkg::EVT_CAL_TIMER_STOPPED]))
    else $error("timer stop not acknowledged in two cycles");
  a_hf_started_evt: assert property ($rose(hf_en_q && high_freq_crystal_osc_ready) |=>
    evt_q[ctei_pkg::EVT_HF])
    else $error("crystal started event missing");
  a_cal_done_evt: assert property (cal_req_q && rc_cal_done |=>
    evt_q[ctei_pkg::EVT_DONE] && !cal_req_q)
    else $error("calibration done event missing");
  a_ct_timeout_evt: assert property (ct_timeout |=> ct_state_q == ctei_pkg::CT_IDLE &&
    evt_q[ctei_pkg::EVT_CAL_TIMER_TIMEOUT])
    else $error("timer timeout did not stop and flag");
  a_lf_snapshot: assert property (t_lf_start |=> src_snap_q == $past(src_sel_q))
    else $error("source snapshot not captured");
  a_irq_follow: assert property ((evt_q & inten_q) != '0 |=> irq_q)
    else $error("interrupt not raised for enabled event");

  c_ct_full_count: cover property (t_ct_start ##[1:300] ct_timeout);
  c_lf_xtal_switch: cover property (lf_src_q == ctei_pkg::SRC_RC && lf_xtal_en_q ##1
    lf_src_q == ctei_pkg::SRC_XTAL);
  c_irq_raised: cover property ($rose(irq_q));

endmodule
`default_nettype wire

/* core/ctei_pkg.sv */
// Shared constants for the clock task, event and status register block.
package ctei_pkg;
  localparam int ADDR_W = 12;
  // Register offsets (byte addresses).
  localparam logic [11:0] OFF_HF_START_TASK = 12'h000;
  localparam logic [11:0] OFF_HF_STOP_TASK = 12'h004;
  localparam logic [11:0] OFF_LF_START_TASK = 12'h008;
  localparam logic [11:0] OFF_LF_STOP_TASK = 12'h00C;
  localparam logic [11:0] OFF_CAL_TASK = 12'h010;
  localparam logic [11:0] OFF_CT_START_TASK = 12'h014;
  localparam logic [11:0] OFF_CT_STOP_TASK = 12'h018;
  localparam logic [11:0] OFF_EVT_HF_STARTED = 12'h100;
  localparam logic [11:0] OFF_EVT_LF_STARTED = 12'h104;
  localparam logic [11:0] OFF_EVT_CAL_DONE = 12'h10C;
  localparam logic [11:0] OFF_EVT_CT_TIMEOUT = 12'h110;
  localparam logic [11:0] OFF_EVT_CT_STARTED = 12'h128;
  localparam logic [11:0] OFF_EVT_CT_STOPPED = 12'h12C;
  localparam logic [11:0] OFF_IRQ_EN_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h308;
  localparam logic [11:0] OFF_HF_RUN_REQ = 12'h408;
  localparam logic [11:0] OFF_HF_STATUS = 12'h40C;
  localparam logic [11:0] OFF_LF_RUN_REQ = 12'h414;
  localparam logic [11:0] OFF_LF_STATUS = 12'h418;
  localparam logic [11:0] OFF_LF_SRC_SNAP = 12'h41C;
  localparam logic [11:0] OFF_LF_SRC_SEL = 12'h518;
  localparam logic [11:0] OFF_CT_INTERVAL = 12'h538;
  // Event numbering, shared by the event flags and the enable bits.
  localparam int NUM_EVT = 6;
  localparam int EVT_HF = 0;
  localparam int EVT_LF = 1;
  localparam int EVT_DONE = 2;
  localparam int EVT_CAL_TIMER_TIMEOUT = 3;
  localparam int EVT_CAL_TIMER_STARTED = 4;
  localparam int EVT_CAL_TIMER_STOPPED = 5;
  localparam logic [11:0] EVT_OFF [NUM_EVT] = '{OFF_EVT_HF_STARTED, OFF_EVT_LF_STARTED,
    OFF_EVT_CAL_DONE, OFF_EVT_CT_TIMEOUT, OFF_EVT_CT_STARTED, OFF_EVT_CT_STOPPED};
  // Field positions.
  localparam int STAT_STATE_BIT = 16;
  localparam int SEL_BYPASS_BIT = 16;
  localparam int SEL_EXTERNAL_BIT = 17;
  // Low-frequency source codes.
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h2;
  // Reset values and bus answers.
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {CT_IDLE, CT_STARTING, CT_RUN, CT_STOPPING} ctei_ct_e;
endpackage

/* bench/test_ctei_clock_ctrl.sv */
// Self-checking bench for the clock task, event and status register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin num_checks++; \
  if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: %s %0h", $time, msg, got); end end
module test_ctei_clock_ctrl;
  localparam logic [1:0] OK = ctei_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ctei_pkg::RESP_SLVERR;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic hf_en, hf_rdy, lf_en, lfx_en, low_freq_rc_osc_rdy, lfx_rdy, cal_req, cal_done, tick, irq;
  int fail_count, num_checks;

  ctei_clock_ctrl #(.CT_W(7)) i_ctei_clock_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .high_freq_crystal_osc_en(hf_en), .high_freq_crystal_osc_ready(hf_rdy),
    .low_freq_clock_en(lf_en), .low_freq_crystal_osc_en(lfx_en),
    .low_freq_rc_osc_ready(low_freq_rc_osc_rdy), .low_freq_crystal_osc_ready(lfx_rdy),
    .rc_cal_request(cal_req), .rc_cal_done(cal_done), .cal_timer_tick(tick), .irq(irq));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ready is sampled at the edge; a response is taken at the edge where its valid is seen.
  // Waits are unbounded here on purpose: only the watchdog may end a stalled transfer.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge aclk);
    end
    `CHK(s_axi_bresp, e, "bresp")
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge aclk);
    end
    `CHK(s_axi_rdata, e, "rdata")
    `CHK(s_axi_rresp, er, "rresp")
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic pulse();
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
    @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Whole sequence needs well under a thousand cycles.
  initial begin
    #(25 * 5000);
    fail_count++;
    end_sim();
  end

  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_arvalid, s_axi_rready, hf_rdy, lfx_rdy, cal_done, tick} <= '0;
    low_freq_rc_osc_rdy <= 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < ctei_pkg::NUM_EVT; i++) rd(ctei_pkg::EVT_OFF[i], 32'h0, OK);
    rd(12'h304, 32'h0, OK);
    rd(12'h418, 32'h0, OK);
    rd(12'h41C, 32'h0, OK);
    `CHK(irq, 1'b0, "irq rst")
    wr(12'h7F0, 32'h1, ERR);
    rd(12'h7F0, 32'h0, ERR);
    wr(12'h000, 32'h1, OK);
    `CHK(hf_en, 1'b1, "hf en")
    rd(12'h000, 32'h0, OK);
    rd(12'h408, 32'h1, OK);
    rd(12'h100, 32'h0, OK);
    hf_rdy <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(12'h100, 32'h1, OK);
    rd(12'h40C, 32'h00010001, OK);
    wr(12'h304, 32'h1, OK);
    rd(12'h304, 32'h1, OK);
    rd(12'h308, 32'h1, OK);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1, "irq on")
    wr(12'h304, 32'h0, OK);
    rd(12'h304, 32'h1, OK);
    wr(12'h308, 32'h1, OK);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0, "irq off")
    rd(12'h308, 32'h0, OK);
    wr(12'h100, 32'h0, OK);
    rd(12'h100, 32'h0, OK);
    wr(12'h004, 32'h1, OK);
    `CHK(hf_en, 1'b0, "hf stop")
    rd(12'h408, 32'h0, OK);
    // Crystal selected but not yet running: the clock must come up on the RC source.
    wr(12'h518, 32'h1, OK);
    wr(12'h008, 32'h1, OK);
    `CHK(lf_en, 1'b1, "lf en")
    `CHK(lfx_en, 1'b1, "lfx en")
    rd(12'h414, 32'h1, OK);
    rd(12'h41C, 32'h1, OK);
    rd(12'h418, 32'h00010000, OK);
    rd(12'h104, 32'h0, OK);
    lfx_rdy <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(12'h418, 32'h00010001, OK);
    rd(12'h104, 32'h1, OK);
    wr(12'h00C, 32'h1, OK);
    `CHK(lf_en, 1'b0, "lf stop")
    `CHK(lfx_en, 1'b0, "lfx stop")
    rd(12'h414, 32'h0, OK);
    wr(12'h518, 32'h2, OK);
    rd(12'h41C, 32'h1, OK);
    wr(12'h008, 32'h1, OK);
    rd(12'h41C, 32'h2, OK);
    rd(12'h418, 32'h00010002, OK);
    wr(12'h00C, 32'h1, OK);
    wr(12'h010, 32'h1, OK);
    `CHK(cal_req, 1'b1, "cal req")
    rd(12'h10C, 32'h0, OK);
    cal_done <= 1'b1;
    @(posedge aclk);
    cal_done <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(cal_req, 1'b0, "cal end")
    rd(12'h10C, 32'h1, OK);
    wr(12'h538, 32'h3, OK);
    wr(12'h014, 32'h1, OK);
    rd(12'h128, 32'h1, OK);
    pulse();
    pulse();
    rd(12'h110, 32'h0, OK);
    pulse();
    rd(12'h110, 32'h1, OK);
    // A stop after timeout finds the timer already idle and answers at once.
    wr(12'h018, 32'h1, OK);
    rd(12'h12C, 32'h1, OK);
    wr(12'h12C, 32'h0, OK);
    wr(12'h128, 32'h0, OK);
    wr(12'h110, 32'h0, OK);
    wr(12'h014, 32'h1, OK);
    rd(12'h128, 32'h1, OK);
    wr(12'h128, 32'h0, OK);
    wr(12'h014, 32'h1, OK);
    rd(12'h128, 32'h1, OK);
    rd(12'h12C, 32'h0, OK);
    wr(12'h018, 32'h1, OK);
    rd(12'h12C, 32'h1, OK);
    // A stopped timer must not count a tick towards a timeout.
    pulse();
    rd(12'h110, 32'h0, OK);
    end_sim();
  end
endmodule
`default_nettype wire
